// ===== rtl/sar_seq.sv
// Conversion sequencer and serial output of a 16-bit SAR converter
`timescale 1ns/1ps
`include "sar_seq_cfg.svh"
module sar_seq
   import sar_seq_pkg::*;
(
   // Core clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // Conversion words from the analog core, core_clk domain
   input wire logic [`RESULT_W-1:0] sample_data,
   input wire logic sample_valid,
   output logic sample_ready,
   // Serial link, runs on the host shift clock
   input wire logic serial_shift_clock,
   input wire logic select_n,
   output logic dout_o,
   output logic dout_oe,
   // Power status, link domain
   output logic analog_on,
   output logic digital_on
);
   ////////////////////////////////////////////////////////////////////////
   // Core side: FIFO of conversion words
   ////////////////////////////////////////////////////////////////////////
   logic f_valid; // Word waiting for the link
   logic [`RESULT_W-1:0] f_data;
   logic f_pop; // Pop pulse from handshake return
   logic in_rdy;

   word_fifo #(.WIDTH(`RESULT_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
      .clk(core_clk),
      .rstn(rstn),
      .in_valid(sample_valid),
      .in_ready(in_rdy),
      .in_data(sample_data),
      .out_valid(f_valid),
      .out_ready(f_pop),
      .out_data(f_data)
   );

   // Ready registered so the output comes from a flip-flop
   // It lags one cycle: a writer that sees it high leaves a cycle between words
   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         sample_ready <= 1'b0;
      end else begin
         sample_ready <= in_rdy;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Word handshake core -> link (req toggle, ack toggle)
   ////////////////////////////////////////////////////////////////////////
   logic req_r; // Toggles when a word is offered
   logic [`RESULT_W-1:0] hold_r; // Stable while req differs from ack
   logic ack_s1_r;
   logic ack_s2_r;
   logic ack_s3_r;
   logic busy_r; // Offer outstanding
   logic ack_r; // Link side toggles this once it has taken hold_r
   // hold_r crosses unsynchronised: it is only read by the link side while
   // req and ack differ, and it cannot change until the ack comes back

   // Offer head word, wait for ack before next; f_pop pops on ack
   // The word leaves the FIFO only on ack, so a frame cut before its
   // fifth fall leaves the word waiting for the next frame
   assign f_pop = busy_r && (ack_s2_r != ack_s3_r);

   always_ff @(posedge core_clk) begin
      if (!rstn) begin
         req_r <= 1'b0;
         busy_r <= 1'b0;
         hold_r <= '0;
         ack_s1_r <= 1'b0;
         ack_s2_r <= 1'b0;
         ack_s3_r <= 1'b0;
      end else begin
         ack_s1_r <= ack_r;
         ack_s2_r <= ack_s1_r;
         ack_s3_r <= ack_s2_r;
         if (f_pop) begin
            busy_r <= 1'b0;
         end else if (!busy_r && f_valid) begin
            hold_r <= f_data;
            req_r <= ~req_r;
            busy_r <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Link domain: clocked by the host shift clock
   ////////////////////////////////////////////////////////////////////////
   // Reset of the link side: core reset synchronised; select high does not enter it
   logic lrst_s1_r;
   logic lrst_s2_r;
   // The shift clock may stand still during reset, so reset is taken into
   // the link side at once and let go only after two falls of its clock
   always_ff @(negedge serial_shift_clock or negedge rstn) begin
      if (!rstn) begin
         lrst_s1_r <= 1'b0;
         lrst_s2_r <= 1'b0;
      end else begin
         lrst_s1_r <= 1'b1;
         lrst_s2_r <= lrst_s1_r;
      end
   end

   logic req_s1_r;
   logic req_s2_r;
   seq_state_e st_r;
   seq_state_e st_nxt;
   logic [`CNT_W-1:0] cnt_r; // Edge counter within the frame
   logic [`RESULT_W-1:0] word_r; // Word being decided/shifted
   logic have_word;

   // A word is waiting while the synchronised request differs from the ack
   assign have_word = (req_s2_r != ack_r);

   // Select high is asynchronous to any shift clock edge: the clock may
   // stand still while select is high, so it clears the sequencer, output and power flops directly
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         ST_IDLE: st_nxt = ST_SAMPLE;
         // Fall 1 leaves idle with the count at zero; falls 2 to 4 count
         // up, so fall 5 is the one that ends sampling
         ST_SAMPLE: if (cnt_r == `SAMPLE_EDGES - 5'h02) st_nxt = ST_ZERO;
         ST_ZERO: st_nxt = ST_MSBF;
         ST_MSBF: if (cnt_r == `MSB_LAST_CNT) st_nxt = ST_LSBF;
         ST_LSBF: if (cnt_r == `REPEAT_LAST_CNT) st_nxt = ST_DONE;
         ST_DONE: st_nxt = ST_DONE;
      endcase
   end

   // Sequencer; select high is the idle state of the link
   // A frame cut short by select leaves no sequencer state behind for the next one
   always_ff @(negedge serial_shift_clock or posedge select_n) begin
      if (select_n) begin
         st_r <= ST_IDLE;
         cnt_r <= 5'h00;
      end else begin
         st_r <= st_nxt;
         if (st_nxt != st_r) begin
            cnt_r <= 5'h00;
         end else begin
            cnt_r <= cnt_r + 5'h01;
         end
      end
   end

   // Request toggle into the link domain; only the second stage is read
   always_ff @(negedge serial_shift_clock) begin
      req_s1_r <= req_r;
      req_s2_r <= req_s1_r;
   end

   // Word capture at sampling end; with no fresh word the last one is sent
   // again rather than stalling the host, which has no way to wait
   always_ff @(negedge serial_shift_clock or negedge lrst_s2_r) begin
      if (!lrst_s2_r) begin
         ack_r <= 1'b0;
         word_r <= '0;
      end else if (st_r == ST_SAMPLE && st_nxt == ST_ZERO) begin
         if (have_word) begin
            word_r <= hold_r;
            ack_r <= ~ack_r;
         end
      end
   end

   // Output driver: each bit goes out on the edge its decision is made
   // Decoding the next state rather than the present one puts the bit on
   // the line at the very fall that decides it
   always_ff @(negedge serial_shift_clock or posedge select_n) begin
      if (select_n) begin
         dout_o <= 1'b0;
         dout_oe <= 1'b0;
      end else begin
         unique case (st_nxt)
            ST_ZERO: begin
               dout_o <= 1'b0;
               dout_oe <= 1'b1;
            end
            ST_MSBF: begin
               // First data fall comes straight from the zero bit with the
               // count cleared; later falls walk down from bit 14
               dout_o <= word_r[(st_r == ST_ZERO) ? 4'hf : 4'he - cnt_r[3:0]];
               dout_oe <= 1'b1;
            end
            ST_LSBF: begin
               dout_o <= word_r[(st_r == ST_MSBF) ? 4'h1 : cnt_r[3:0] + 4'h2];
               dout_oe <= 1'b1;
            end
            ST_DONE: begin
               dout_o <= 1'b0;
               dout_oe <= 1'b0;
            end
            default: begin
               dout_o <= 1'b0;
               dout_oe <= 1'b0;
            end
         endcase
      end
   end

   // Power state: analog off once the LSB-first repeat starts, digital off only with select high
   // The repeat phase runs on digital power alone: the last decision has
   // been made, so the comparator and array are left unpowered
   always_ff @(negedge serial_shift_clock or posedge select_n) begin
      if (select_n) begin
         analog_on <= 1'b0;
         digital_on <= 1'b0;
      end else begin
         digital_on <= 1'b1;
         analog_on <= (st_nxt == ST_SAMPLE) || (st_nxt == ST_ZERO) ||
                      (st_nxt == ST_MSBF);
      end
   end
endmodule // sar_seq

// ===== rtl/sar_seq_cfg.svh
// Timing counts and bit positions for the converter sequencer
// Functional notes
// - Done with select low: analog off, digital on
// - Select high forces full digital shutdown
// - Each decided bit goes out immediately
// - One decision per shift cycle, previous shown
// - Select high abandons conversion at any point
// - Select falling edge starts sample and conversion
// - Fifth falling edge: low bit, then MSB-first result
// - Then LSB-first repeat, tri-state after MSB
// - New conversion needs select high then low
`ifndef SAR_SEQ_CFG_SVH
`define SAR_SEQ_CFG_SVH
`define RESULT_W 16
`define SAMPLE_EDGES 5'h05
`define MSB_LAST_CNT 5'h0f
`define REPEAT_LAST_CNT 5'h0e
`define CNT_W 5
`define FIFO_DEPTH 4
`endif

// ===== rtl/sar_seq_pkg.sv
// Types shared by the converter sequencer
package sar_seq_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_SAMPLE = 3'b001,
      ST_ZERO = 3'b010,
      ST_MSBF = 3'b011,
      ST_LSBF = 3'b100,
      ST_DONE = 3'b101
   } seq_state_e;
endpackage

// ===== rtl/word_fifo.sv
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 4
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   localparam int AW1 = AW + 1; // Width of the fill level
   logic [WIDTH-1:0] mem_r [DEPTH]; // Storage
   logic [AW-1:0] wr_r; // Write index
   logic [AW-1:0] rd_r; // Read index
   logic [AW:0] cnt_r; // Fill level
   logic push;
   logic pop;

   assign in_ready = (cnt_r != AW1'(DEPTH));
   assign out_valid = (cnt_r != '0);
   assign out_data = mem_r[rd_r];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   // Storage write, no reset needed for data
   always_ff @(posedge clk) begin
      if (push) begin
         mem_r[wr_r] <= in_data;
      end
   end

   // Pointers and level
   always_ff @(posedge clk) begin
      if (!rstn) begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
      end else begin
         if (push) begin
            wr_r <= (wr_r == AW'(DEPTH - 1)) ? '0 : wr_r + 1'b1;
         end
         if (pop) begin
            rd_r <= (rd_r == AW'(DEPTH - 1)) ? '0 : rd_r + 1'b1;
         end
         cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      end
   end
endmodule // word_fifo

// ===== verif/sar_seq_sva.sv
// Port checker for the converter sequencer
`timescale 1ns/1ps
module sar_seq_sva (
   // Core side
   input wire logic core_clk,
   input wire logic rstn,
   // Link side
   input wire logic serial_shift_clock,
   input wire logic select_n,
   input wire logic dout_o,
   input wire logic dout_oe,
   input wire logic analog_on,
   input wire logic digital_on
);
   logic [5:0] cnt_r; // Falls seen this frame
   logic [36:0] hist_r; // Line value by fall number
   // Count falls; select high clears, as the link side does
   always_ff @(negedge serial_shift_clock or posedge select_n) begin
      if (select_n)
         cnt_r <= 6'h00;
      else if (cnt_r != 6'h3f)
         cnt_r <= cnt_r + 6'h01;
   end
   // Sample mid-cycle, where the line has settled
   always_ff @(posedge serial_shift_clock) begin
      if (cnt_r < 6'h25)
         hist_r[cnt_r] <= dout_o;
   end
   AST_SEL_OFF: assert property (@(posedge core_clk) disable iff (!rstn)
      select_n && $past(select_n) |-> !dout_oe && !digital_on && !analog_on)
      else $error("outputs active while deselected");
   AST_STILL: assert property (@(posedge core_clk) disable iff (!rstn)
      serial_shift_clock && $past(serial_shift_clock) |-> $stable(dout_o))
      else $error("line moved without a fall");
   AST_OE_ON: assert property (@(posedge serial_shift_clock) disable iff (select_n)
      cnt_r inside {[5:36]} |-> dout_oe)
      else $error("line not driven in frame");
   AST_OE_OFF: assert property (@(posedge serial_shift_clock) disable iff (select_n)
      cnt_r < 6'h05 || cnt_r > 6'h24 |-> !dout_oe)
      else $error("line driven outside data");
   AST_ZERO: assert property (@(posedge serial_shift_clock) disable iff (select_n)
      cnt_r == 6'h05 |-> !dout_o)
      else $error("leading bit not low");
   AST_MIRROR: assert property (@(posedge serial_shift_clock) disable iff (select_n)
      cnt_r inside {[22:36]} |-> dout_o == hist_r[6'h2a - cnt_r])
      else $error("repeat does not mirror result");
   AST_DONE_PWR: assert property (@(posedge serial_shift_clock) disable iff (select_n)
      cnt_r > 6'h24 |-> !analog_on && digital_on)
      else $error("wrong power state when done");
   AST_RUN_PWR: assert property (@(posedge serial_shift_clock) disable iff (select_n)
      cnt_r inside {[1:4]} |-> digital_on)
      else $error("digital off while sampling");
   AST_CONV_PWR: assert property (@(posedge serial_shift_clock) disable iff (select_n)
      cnt_r inside {[1:21]} |-> analog_on)
      else $error("analog off before conversion end");
endmodule // sar_seq_sva
bind sar_seq sar_seq_sva u_chk (.core_clk, .rstn, .serial_shift_clock, .select_n, .dout_o,
   .dout_oe, .analog_on, .digital_on);

// ===== verif/host_model.sv
// Host model: drives select and shift clock, captures the line
`timescale 1ns/1ps
module host_model (
   // Serial link
   output logic serial_shift_clock,
   output logic select_n,
   input wire logic dout_o,
   input wire logic dout_oe,
   // Power status
   input wire logic analog_on,
   input wire logic digital_on,
   // Captures by fall number
   output logic [40:1] cap_oe,
   output logic [40:1] cap_d,
   output logic [1:0] cap_pw
);
   // Idle: clock low, deselected
   initial begin
      serial_shift_clock = 1'b0;
      // A clean rising select clears the sequencer and outputs before the first frame
      select_n = 1'b0;
      #5 select_n = 1'b1;
   end
   // One frame of n falls; short n ends it early
   task automatic frame(input int n);
      select_n = 1'b0;
      #40;
      for (int k = 1; k <= n; k++) begin
         serial_shift_clock = 1'b1;
         #62.5 serial_shift_clock = 1'b0;
         #62.5 cap_oe[k] = dout_oe;
         cap_d[k] = dout_o & dout_oe; // Undriven line counts as 0
      end
      cap_pw = {analog_on, digital_on};
      select_n = 1'b1;
      #500;
   endtask
endmodule // host_model

// ===== verif/sar_seq_bench.sv
// Testbench for the converter sequencer
`timescale 1ns/1ps
`include "sar_seq_cfg.svh"
module sar_seq_bench;
   logic core_clk = 1'b0;
   logic rstn = 1'b1; // Lowered at time zero so the fall is seen
   logic [`RESULT_W-1:0] sample_data = 16'h0000;
   logic sample_valid = 1'b0;
   logic sample_ready, serial_shift_clock, select_n, dout_o, dout_oe, analog_on, digital_on;
   logic [40:1] cap_oe, cap_d;
   logic [1:0] cap_pw;
   logic [15:0] lfsr_r = 16'h6b8f; // Seed 27535
   logic [15:0] q[$]; // Words in flight
   int err_total = 0;
   int checks_done = 0;
   int cycles = 0;
   int lens[4] = '{38, 19, 8, 37}; // Full, 14 bits, 3 bits, just done
   sar_seq dut (.core_clk, .rstn, .sample_data, .sample_valid, .sample_ready,
      .serial_shift_clock, .select_n, .dout_o, .dout_oe, .analog_on, .digital_on);
   host_model u_host (.serial_shift_clock, .select_n, .dout_o, .dout_oe, .analog_on,
      .digital_on, .cap_oe, .cap_d, .cap_pw);
   ////////////////////////////////////////////////////////////////
   always #12.5 core_clk = ~core_clk;
   // Hang guard
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         final_report;
      end
   end
   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // Expected {oe, data} after fall k
   function automatic logic [1:0] exp_line(input logic [15:0] w, input int k);
      if (k < 5 || k > 36)
         return 2'b00;
      if (k == 5)
         return 2'b10;
      if (k <= 21)
         return {1'b1, w[21-k]};
      return {1'b1, w[k-21]};
   endfunction
   task automatic check(input string what, input logic [1:0] seen, input logic [1:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report;
      if (err_total == 0 && checks_done > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Offer one random word once ready, gap after
   task automatic push;
      for (int t = 0; t < 200 && sample_ready !== 1'b1; t++)
         @(posedge core_clk);
      lfsr_r = lfsr_next(lfsr_r);
      sample_data <= lfsr_r;
      sample_valid <= 1'b1;
      q.push_back(lfsr_r);
      @(posedge core_clk);
      sample_valid <= 1'b0;
      @(posedge core_clk);
   endtask
   // One frame, every fall compared
   task automatic run(input int n);
      logic [15:0] w;
      w = q.pop_front();
      u_host.frame(n);
      for (int k = 1; k <= n; k++)
         check("line", {cap_oe[k], cap_d[k]}, exp_line(w, k));
      check("power", cap_pw, (n > 21) ? 2'b01 : 2'b11);
      check("idle", {dout_oe, digital_on}, 2'b00);
   endtask
   initial begin
      rstn <= 1'b0;
      repeat (6) @(posedge core_clk);
      rstn <= 1'b1;
      @(posedge core_clk);
      repeat (4) push;
      @(posedge core_clk);
      check("full", {1'b0, sample_ready}, 2'b00);
      for (int i = 0; i < 12; i++) begin
         lfsr_r = lfsr_next(lfsr_r);
         run(i < 4 ? lens[i] : 6 + int'(lfsr_r % 35));
         @(posedge core_clk);
         push;
      end
      final_report;
   end
endmodule // sar_seq_bench
